// File: dv/drive_config_object_bank_tb.sv
`timescale 1ns/1ps
`include "drive_cfg_defines.svh"
`define CHK(g, e) chk(32'(g), 32'(e))

module drive_config_object_bank_tb;
	// ****
	// Signals
	// ****
	logic clk, rstn, tick, req, wr, ack, err;
	logic [15:0] idx;
	logic [15:0] statusword;
	logic [7:0] sub;
	logic [31:0] wdata, rdata, limit, active;
	logic signed [31:0] actual, target, count, scaled, abs_pos;
	logic vel, reaction, slip, evt, log_req, step_valid, ccw, scaled_valid, fitted, ready;
	int n_fail = 0;
	int cmp_count = 0;
	int n_evt = 0;
	int n_log = 0;

	// ****
	// Design and master
	// ****
	drive_config_object_bank u_dut (.sys_clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .tick_ms_i(tick),
		.obj_req_i(req), .obj_wr_i(wr), .obj_index_i(idx), .obj_sub_i(sub), .obj_wdata_i(wdata),
		.obj_ack_o(ack), .obj_err_o(err), .obj_rdata_o(rdata), .velocity_mode_i(vel),
		.actual_speed_i(actual), .target_speed_i(target), .slip_limit_i(limit),
		.slip_reaction_set_i(reaction), .status_slip_o(slip), .statusword_o(statusword),
		.slip_event_o(evt), .error_log_o(log_req), .step_valid_i(step_valid), .step_count_i(count),
		.step_ccw_mode_o(ccw), .scaled_valid_o(scaled_valid), .scaled_steps_o(scaled),
		.abs_encoder_fitted_i(fitted), .abs_position_user_i(abs_pos), .ready_o(ready), .iface_active_o(active));

	fieldbus_master_model u_master (.clk_i(clk), .obj_ack_i(ack), .obj_err_i(err), .obj_rdata_i(rdata),
		.obj_req_o(req), .obj_wr_o(wr), .obj_index_o(idx), .obj_sub_o(sub), .obj_wdata_o(wdata));

	// Free-running clock of 50 ns.
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// One-cycle pulses are counted at every rising edge so that none slips past a later check.
	always @(posedge clk)
	begin
		if (evt === 1'b1)
			n_evt++;
		if (log_req === 1'b1)
			n_log++;
	end

	// ****
	// Helpers
	// ****
	task automatic close_out();
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// A lost answer ends the run at once, since every later result would be meaningless.
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		logic lost;
		u_master.access(w, i, s, d, r, e, lost);
		if (lost)
		begin
			n_fail++;
			close_out();
		end
	endtask

	task automatic rd_chk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		acc(1'b0, i, s, 32'h00000000, r, e);
		`CHK(e, 1'b0);
		`CHK(r, x);
	endtask

	task automatic wr_chk(input logic [15:0] i, input logic [31:0] d, input logic xe);
		logic [31:0] r;
		logic e;
		acc(1'b1, i, 8'h00, d, r, e);
		`CHK(e, xe);
	endtask

	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
	endtask

	task automatic step(input logic signed [31:0] c, input logic signed [31:0] x);
		@(posedge clk);
		step_valid <= 1'b1;
		count <= c;
		@(posedge clk);
		step_valid <= 1'b0;
		#1;
		`CHK(scaled_valid, 1'b1);
		`CHK(scaled, x);
	endtask

	task automatic reset_with(input logic f, input logic signed [31:0] p);
		@(posedge clk);
		rstn <= 1'b0;
		fitted <= f;
		abs_pos <= p;
		#1;
		`CHK(ready, 1'b0);
		`CHK(active, 32'h0019000B);
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		`CHK(ready, 1'b1);
	endtask

	// ****
	// Scenarios
	// ****
	task automatic check_defaults();
		logic [15:0] ix [0:9] = '{16'h203F, 16'h2057, 16'h2058, 16'h205A, 16'h205B, 16'h2084, 16'h2101,
			16'h2102, 16'h2103, 16'h2103};
		logic [7:0] sb [0:9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};
		logic [31:0] ex [0:9] = '{32'h00000064, 32'h00000080, 32'h00000001, 32'h00000000, 32'h00000000,
			32'h00000000, 32'h0019000B, 32'h0019000B, 32'h0000000A, 32'h0019000B};
		for (int k = 0; k < 10; k++)
			rd_chk(ix[k], sb[k], ex[k]);
		`CHK(active, 32'h0019000B);
		`CHK(statusword, 16'h0000);
		`CHK(ccw, 1'b0);
	endtask

	task automatic check_access();
		logic [31:0] r;
		logic e;
		wr_chk(`IDX_IF_CTRL, 32'h00000000, 1'b0);
		rd_chk(`IDX_IF_CTRL, 8'h00, 32'h00190001);
		`CHK(active, 32'h00190001);
		rd_chk(`IDX_IF_STATUS, `SUB_IF_ACTIVE, 32'h00190001);
		wr_chk(`IDX_IF_CTRL, 32'h00000008, 1'b0);
		`CHK(active, 32'h00190009);
		wr_chk(`IDX_IF_CTRL, 32'hFFFFFFFF, 1'b0);
		rd_chk(`IDX_IF_CTRL, 8'h00, 32'h0019000B);
		wr_chk(`IDX_IF_AVAIL, 32'h00000000, 1'b1);
		rd_chk(`IDX_IF_AVAIL, 8'h00, 32'h0019000B);
		wr_chk(`IDX_BOOT_POS, 32'h00000005, 1'b1);
		wr_chk(`IDX_IF_STATUS, 32'h00000000, 1'b1);
		acc(1'b0, 16'h2000, 8'h00, 32'h00000000, r, e);
		`CHK(e, 1'b1);
		wr_chk(`IDX_SLIP_TIMEOUT, 32'h1234ABCD, 1'b0);
		rd_chk(`IDX_SLIP_TIMEOUT, 8'h00, 32'h0000ABCD);
		wr_chk(`IDX_START_DELAY, 32'h00000005, 1'b0);
		rd_chk(`IDX_START_DELAY, 8'h00, 32'h00000005);
	endtask

	task automatic check_steps();
		step(32'sd3, 32'sd384);
		step(-32'sd3, -32'sd384);
		wr_chk(`IDX_STEP_MULT, 32'h00000006, 1'b0);
		wr_chk(`IDX_STEP_DIV, 32'h00000004, 1'b0);
		step(32'sd7, 32'sd10);
		step(-32'sd7, -32'sd10);
		wr_chk(`IDX_STEP_MODE, 32'h00000001, 1'b0);
		step(32'sd7, 32'sd7);
		`CHK(ccw, 1'b1);
		wr_chk(`IDX_STEP_MODE, 32'h00000000, 1'b0);
		step(32'sd7, 32'sd10);
		`CHK(ccw, 1'b0);
	endtask

	// Deviation above the limit in both directions, a restart of the count, and a reaction turned off.
	task automatic check_slip();
		wr_chk(`IDX_SLIP_TIMEOUT, 32'h00000002, 1'b0);
		@(posedge clk);
		actual <= 32'sd85;
		ticks(3);
		`CHK(slip, 1'b0);
		@(posedge clk);
		vel <= 1'b1;
		ticks(2);
		`CHK(slip, 1'b0);
		ticks(1);
		repeat (3) @(posedge clk);
		#1;
		`CHK(statusword, 16'h2000);
		`CHK(n_evt, 1);
		`CHK(n_log, 1);
		@(posedge clk);
		actual <= 32'sd105;
		repeat (2) @(posedge clk);
		#1;
		`CHK(slip, 1'b0);
		@(posedge clk);
		actual <= 32'sd115;
		ticks(2);
		@(posedge clk);
		actual <= 32'sd100;
		@(posedge clk);
		actual <= 32'sd115;
		reaction <= 1'b0;
		ticks(2);
		repeat (3) @(posedge clk);
		#1;
		`CHK(slip, 1'b0);
		ticks(1);
		repeat (3) @(posedge clk);
		#1;
		`CHK(slip, 1'b1);
		`CHK(n_evt, 2);
		`CHK(n_log, 1);
		@(posedge clk);
		vel <= 1'b0;
		actual <= 32'sd100;
	endtask

	task automatic check_boot();
		reset_with(1'b1, -32'sd5);
		@(posedge clk);
		abs_pos <= 32'sd77;
		rd_chk(`IDX_BOOT_POS, 8'h00, 32'hFFFFFFFB);
		reset_with(1'b0, 32'sd9);
		rd_chk(`IDX_BOOT_POS, 8'h00, 32'h00000000);
	endtask

	// Main sequence.
	initial
	begin
		rstn = 1'b0;
		tick = 1'b0;
		vel = 1'b0;
		actual = 32'sd100;
		target = 32'sd100;
		limit = 32'h0000000A;
		reaction = 1'b1;
		step_valid = 1'b0;
		count = 32'sd0;
		fitted = 1'b0;
		abs_pos = 32'sd0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		check_defaults();
		check_access();
		check_steps();
		check_slip();
		check_boot();
		close_out();
	end
endmodule

// File: dv/fieldbus_master_model.sv
`timescale 1ns/1ps

// ****
// Fieldbus master model
// ****
module fieldbus_master_model
(
	// Clock.
	input wire logic clk_i,
	// Answer from the object bank.
	input wire logic obj_ack_i,
	input wire logic obj_err_i,
	input wire logic [31:0] obj_rdata_i,
	// Request to the object bank.
	output logic obj_req_o,
	output logic obj_wr_o,
	output logic [15:0] obj_index_o,
	output logic [7:0] obj_sub_o,
	output logic [31:0] obj_wdata_o
);
	// Idle at time zero, before any access is made.
	initial
	begin
		obj_req_o = 1'b0;
		obj_wr_o = 1'b0;
		obj_index_o = 16'h0000;
		obj_sub_o = 8'h00;
		obj_wdata_o = 32'h00000000;
	end

	// One access is a request level of one cycle; the answer is awaited for a bounded time.
	task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
		output logic [31:0] rd, output logic er, output logic lost);
		int n;
		n = 0;
		lost = 1'b1;
		@(posedge clk_i);
		obj_req_o <= 1'b1;
		obj_wr_o <= wr;
		obj_index_o <= idx;
		obj_sub_o <= sub;
		obj_wdata_o <= wd;
		@(posedge clk_i);
		obj_req_o <= 1'b0;
		obj_index_o <= ~idx; // Released index and data lines show a changed pattern, so stale values cannot pass.
		obj_wdata_o <= ~wd;
		while (n < 8 && lost)
		begin
			@(posedge clk_i);
			n++;
			if (obj_ack_i === 1'b1)
			begin
				rd = obj_rdata_i;
				er = obj_err_i;
				lost = 1'b0;
			end
		end
	endtask
endmodule

// File: logic/drive_cfg_defines.svh
`ifndef DRIVE_CFG_DEFINES_SVH
`define DRIVE_CFG_DEFINES_SVH

// ****************************************
// Object indices
// ****************************************
`define IDX_SLIP_TIMEOUT 16'h203F
`define IDX_STEP_MULT 16'h2057
`define IDX_STEP_DIV 16'h2058
`define IDX_BOOT_POS 16'h205A
`define IDX_STEP_MODE 16'h205B
`define IDX_START_DELAY 16'h2084
`define IDX_IF_AVAIL 16'h2101
`define IDX_IF_CTRL 16'h2102
`define IDX_IF_STATUS 16'h2103
`define SUB_IF_MASK 8'h01
`define SUB_IF_ACTIVE 8'h02

// ****************************************
// Reset values and fixed contents
// ****************************************
`define RST_SLIP_TIMEOUT 16'h0064
`define RST_STEP_MULT 32'h00000080
`define RST_STEP_DIV 32'h00000001
`define RST_STEP_MODE 32'h00000000
`define RST_START_DELAY 32'h00000000
`define IF_AVAIL_VALUE 32'h0019000B
`define RST_IF_CTRL 32'h0019000B
`define IF_SWITCH_MASK 32'h0000000A

// ****************************************
// Interface bitmap layout
// ****************************************
`define BIT_USB 0
`define BIT_RS485 1
`define BIT_RS232 2
`define BIT_CAN 3
`define BIT_PLAIN_ETHERNET_INTERFACE 4
`define BIT_REALTIME_INDUSTRIAL_ETHERNET 5
`define BIT_SPI 6
`define BIT_MODBUS_SERIAL_PROTOCOL 16
`define BIT_MODBUS_NETWORK_PROTOCOL 17
`define BIT_INDUSTRIAL_ETHERNET_APP_PROTOCOL 18
`define PHYS_MSB 15
`define PROTO_LSB 16
`define STATUS_SLIP_BIT 13

`endif

// File: logic/drive_cfg_pkg.sv
package drive_cfg_pkg;

	// Slip monitor state.
	typedef struct packed {
		logic [16:0] cnt;
		logic err;
	} slip_state_s;

	// Step scaler state.
	typedef struct packed {
		logic [31:0] steps;
		logic valid;
	} scale_state_s;

	// Object bank state.
	typedef struct packed {
		logic [15:0] slip_to;
		logic [31:0] mult;
		logic [31:0] div;
		logic [31:0] mode;
		logic [31:0] delay;
		logic [31:0] ctrl;
		logic [31:0] boot_pos;
		logic booted;
		logic [31:0] up_ms;
		logic ready;
		logic ack;
		logic err;
		logic [31:0] rdata;
	} bank_state_s;

endpackage

// File: logic/drive_config_object_bank.sv
`timescale 1ns/1ps
`include "drive_cfg_defines.svh"

// What this block does
// - Velocity mode slip sets statusword bit 13.
// - Slip reported after timeout, default 0x64 ms.
// - Configured reaction also logs history entry.
// - Pulse/direction count multiplied, default 0x80.
// - Pulse/direction count divided, default one.
// - Mode select: 0 pulse/direction, 1 cw/ccw.
// - Capture absolute position at power-on.
// - No absolute encoder: boot position zero.
// - Readiness waits startup delay in milliseconds.
// - Low half interfaces, high half protocols.
// - Physical interface bits 0 to 6.
// - Protocol bits 16 to 18.
// - Availability bitmap fixed at 0x0019000B.
// - Control bitmap switches only switchable bits.
// - Separate read-only active status bitmap.
// - Switchability mask fixed at 0x0000000A.
// - Active bit one means running.

module drive_config_object_bank
(
	// Clock, reset, enable and time base.
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic tick_ms_i,
	// Object access port.
	input wire logic obj_req_i,
	input wire logic obj_wr_i,
	input wire logic [15:0] obj_index_i,
	input wire logic [7:0] obj_sub_i,
	input wire logic [31:0] obj_wdata_i,
	output logic obj_ack_o,
	output logic obj_err_o,
	output logic [31:0] obj_rdata_o,
	// Velocity loop and slip handling.
	input wire logic velocity_mode_i,
	input wire logic signed [31:0] actual_speed_i,
	input wire logic signed [31:0] target_speed_i,
	input wire logic [31:0] slip_limit_i,
	input wire logic slip_reaction_set_i,
	output logic status_slip_o,
	output logic [15:0] statusword_o,
	output logic slip_event_o,
	output logic error_log_o,
	// Step input.
	input wire logic step_valid_i,
	input wire logic signed [31:0] step_count_i,
	output logic step_ccw_mode_o,
	output logic scaled_valid_o,
	output logic signed [31:0] scaled_steps_o,
	// Absolute encoder.
	input wire logic abs_encoder_fitted_i,
	input wire logic signed [31:0] abs_position_user_i,
	// Readiness and interface enables.
	output logic ready_o,
	output logic [31:0] iface_active_o
);

	// ****************************************
	// Reset release
	// ****************************************

	logic [1:0] rst_sync_q;
	logic rst_n;

	// Assert at once, release only after two clean edges.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n = rst_sync_q[1];

	// ****************************************
	// Helpers
	// ****************************************

	// Keeps the bits that may not be switched at their current value.
	function automatic logic [31:0] merge_switchable(input logic [31:0] cur, input logic [31:0] req);
		merge_switchable = (req & `IF_SWITCH_MASK) | (cur & ~`IF_SWITCH_MASK);
	endfunction

	// True when the index holds an object that only reads.
	function automatic logic is_read_only(input logic [15:0] idx);
		is_read_only = (idx == `IDX_BOOT_POS) || (idx == `IDX_IF_AVAIL) || (idx == `IDX_IF_STATUS);
	endfunction

	drive_cfg_pkg::bank_state_s s_q, s_d;
	logic slip_err;
	logic slip_err_q;
	logic [31:0] active_map;
	logic [31:0] rd_val;
	logic rd_hit;

	// ****************************************
	// Sub-blocks
	// ****************************************

	slip_monitor u_slip
	(
		.clk_i(sys_clk_i),
		.rst_ni(rst_n),
		.ce_i(ce_i),
		.tick_ms_i(tick_ms_i),
		.velocity_mode_i(velocity_mode_i),
		.actual_speed_i(actual_speed_i),
		.target_speed_i(target_speed_i),
		.slip_limit_i(slip_limit_i),
		.timeout_ms_i(s_q.slip_to),
		.slip_err_o(slip_err)
	);

	step_scaler u_scale
	(
		.clk_i(sys_clk_i),
		.rst_ni(rst_n),
		.ce_i(ce_i),
		.ccw_mode_i(step_ccw_mode_o),
		.mult_i(s_q.mult),
		.div_i(s_q.div),
		.step_valid_i(step_valid_i),
		.step_count_i(step_count_i),
		.scaled_valid_o(scaled_valid_o),
		.scaled_steps_o(scaled_steps_o)
	);

	// ****************************************
	// Object read decode
	// ****************************************

	// Running interfaces are those enabled and actually fitted.
	assign active_map = s_q.ctrl & `IF_AVAIL_VALUE;

	// Read multiplexer over the object indices.
	always_comb
	begin
		rd_val = 32'h00000000;
		rd_hit = 1'b1;
		unique case (obj_index_i)
			`IDX_SLIP_TIMEOUT: rd_val = {16'h0000, s_q.slip_to};
			`IDX_STEP_MULT: rd_val = s_q.mult;
			`IDX_STEP_DIV: rd_val = s_q.div;
			`IDX_BOOT_POS: rd_val = abs_encoder_fitted_i ? s_q.boot_pos : 32'h00000000;
			`IDX_STEP_MODE: rd_val = s_q.mode;
			`IDX_START_DELAY: rd_val = s_q.delay;
			`IDX_IF_AVAIL: rd_val = `IF_AVAIL_VALUE;
			`IDX_IF_CTRL: rd_val = s_q.ctrl;
			`IDX_IF_STATUS:
			begin
				if (obj_sub_i == `SUB_IF_MASK)
					rd_val = `IF_SWITCH_MASK;
				else if (obj_sub_i == `SUB_IF_ACTIVE)
					rd_val = active_map;
				else
					rd_hit = 1'b0;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************

	// Object writes, boot capture, readiness timing and access answers.
	always_comb
	begin
		s_d = s_q;
		s_d.ack = 1'b0;
		s_d.err = 1'b0;
		if (obj_req_i)
		begin
			s_d.ack = 1'b1;
			s_d.rdata = rd_val;
			s_d.err = !rd_hit || (obj_wr_i && is_read_only(obj_index_i));
			if (!obj_wr_i)
				s_d.rdata = rd_hit ? rd_val : 32'h00000000;
			else
			begin
				s_d.rdata = 32'h00000000;
				unique case (obj_index_i)
					`IDX_SLIP_TIMEOUT: s_d.slip_to = obj_wdata_i[15:0];
					`IDX_STEP_MULT: s_d.mult = obj_wdata_i;
					`IDX_STEP_DIV: s_d.div = obj_wdata_i;
					`IDX_STEP_MODE: s_d.mode = obj_wdata_i;
					`IDX_START_DELAY: s_d.delay = obj_wdata_i;
					`IDX_IF_CTRL: s_d.ctrl = merge_switchable(s_q.ctrl, obj_wdata_i);
					default: s_d.err = 1'b1;
				endcase
				if (is_read_only(obj_index_i))
					s_d.err = 1'b1;
			end
		end
		// The encoder value is taken once, on the first enabled edge after release.
		if (!s_q.booted)
		begin
			s_d.booted = 1'b1;
			s_d.boot_pos = abs_encoder_fitted_i ? abs_position_user_i : 32'h00000000;
		end
		// Uptime saturates so a very long delay still ends.
		if (tick_ms_i && s_q.up_ms != 32'hFFFFFFFF)
			s_d.up_ms = s_q.up_ms + 32'h00000001;
		if (s_q.booted && s_q.up_ms >= s_q.delay)
			s_d.ready = 1'b1;
	end

	// ****************************************
	// State register
	// ****************************************

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.slip_to <= `RST_SLIP_TIMEOUT;
			s_q.mult <= `RST_STEP_MULT;
			s_q.div <= `RST_STEP_DIV;
			s_q.mode <= `RST_STEP_MODE;
			s_q.delay <= `RST_START_DELAY;
			s_q.ctrl <= `RST_IF_CTRL;
		end
		else if (ce_i)
			s_q <= s_d;
	end

	// Edge of the slip flag, used to log one history entry per error.
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			slip_err_q <= 1'b0;
		else if (ce_i)
			slip_err_q <= slip_err;
	end

	// ****************************************
	// Outputs
	// ****************************************

	// Event pulses are gated by the enable so a frozen block emits none.
	assign status_slip_o = slip_err;
	assign statusword_o = 16'(slip_err) << `STATUS_SLIP_BIT;
	assign slip_event_o = ce_i && slip_err && !slip_err_q;
	assign error_log_o = slip_event_o && slip_reaction_set_i;
	assign step_ccw_mode_o = s_q.mode[0];
	assign ready_o = s_q.ready;
	assign iface_active_o = active_map;
	assign obj_ack_o = s_q.ack;
	assign obj_err_o = s_q.err;
	assign obj_rdata_o = s_q.rdata;

	// ****************************************
	// Checks
	// ****************************************

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);

	a_ctrl_locked: assert property (ce_i && obj_req_i && obj_wr_i && obj_index_i == `IDX_IF_CTRL
		|=> (s_q.ctrl & ~`IF_SWITCH_MASK) == ($past(s_q.ctrl) & ~`IF_SWITCH_MASK))
		else $error("non-switchable interface changed");
	a_ctrl_switch: assert property (ce_i && obj_req_i && obj_wr_i && obj_index_i == `IDX_IF_CTRL
		|=> (s_q.ctrl & `IF_SWITCH_MASK) == ($past(obj_wdata_i) & `IF_SWITCH_MASK))
		else $error("switchable interface not applied");
	a_avail_read: assert property (ce_i && obj_req_i && !obj_wr_i && obj_index_i == `IDX_IF_AVAIL
		|=> obj_ack_o && obj_rdata_o == 32'h0019000B && !obj_err_o)
		else $error("availability read wrong");
	a_mask_read: assert property (ce_i && obj_req_i && !obj_wr_i && obj_index_i == `IDX_IF_STATUS
		&& obj_sub_i == `SUB_IF_MASK |=> obj_rdata_o == 32'h0000000A)
		else $error("switch mask read wrong");
	a_active_subset: assert property (iface_active_o == (s_q.ctrl & 32'h0019000B))
		else $error("active map not enable and availability");
	a_boot_zero: assert property (ce_i && !s_q.booted && !abs_encoder_fitted_i |=> s_q.boot_pos == 32'h00000000)
		else $error("boot position not zero without encoder");
	a_boot_hold: assert property (s_q.booted |=> s_q.boot_pos == $past(s_q.boot_pos))
		else $error("boot position changed after capture");
	a_ready_wait: assert property ($rose(ready_o) |-> $past(s_q.up_ms) >= $past(s_q.delay))
		else $error("ready before startup delay");
	a_log_gated: assert property (error_log_o |-> slip_reaction_set_i && $rose(status_slip_o))
		else $error("history entry without reaction");
	a_status_bit: assert property (statusword_o[13] == status_slip_o && statusword_o[12:0] == 13'h0000)
		else $error("slip not on statusword bit 13");

	// Every accepted access is answered in the very next cycle and never without a request.
	// The host relies on this fixed latency, so a lost or doubled answer would misalign its reads.
	a_ack_follows: assert property (ce_i && obj_req_i |=> obj_ack_o)
		else $error("access not answered");
	a_ack_single: assert property (ce_i && !obj_req_i |=> !obj_ack_o)
		else $error("answer without access");

	// Writes to objects that only read are refused and leave the captured value alone.
	a_ro_refused: assert property (ce_i && obj_req_i && obj_wr_i && is_read_only(obj_index_i)
		|=> obj_err_o)
		else $error("write to read-only object accepted");
	a_ro_boot_kept: assert property (ce_i && obj_req_i && obj_wr_i && obj_index_i == `IDX_BOOT_POS
		|=> s_q.boot_pos == $past(s_q.boot_pos))
		else $error("boot position overwritten");

	// The active map read through the status object matches the running set shown on the port.
	a_active_read: assert property (ce_i && obj_req_i && !obj_wr_i && obj_index_i == `IDX_IF_STATUS
		&& obj_sub_i == `SUB_IF_ACTIVE |=> obj_rdata_o == $past(iface_active_o))
		else $error("active map read wrong");

	// Configuration writes land in full, except the slip timeout which keeps only bits 15:0, so the scaler and monitor see what the host sent.
	a_timeout_write: assert property (ce_i && obj_req_i && obj_wr_i && obj_index_i == `IDX_SLIP_TIMEOUT
		|=> s_q.slip_to == $past(obj_wdata_i[15:0]))
		else $error("slip timeout write lost");
	a_mult_write: assert property (ce_i && obj_req_i && obj_wr_i && obj_index_i == `IDX_STEP_MULT
		|=> s_q.mult == $past(obj_wdata_i))
		else $error("multiplier write lost");
	a_div_write: assert property (ce_i && obj_req_i && obj_wr_i && obj_index_i == `IDX_STEP_DIV
		|=> s_q.div == $past(obj_wdata_i))
		else $error("divider write lost");
	a_mode_write: assert property (ce_i && obj_req_i && obj_wr_i && obj_index_i == `IDX_STEP_MODE
		|=> step_ccw_mode_o == $past(obj_wdata_i[0]))
		else $error("input mode not applied");
	a_delay_write: assert property (ce_i && obj_req_i && obj_wr_i && obj_index_i == `IDX_START_DELAY
		|=> s_q.delay == $past(obj_wdata_i))
		else $error("startup delay write lost");

	// Readiness is sticky; a later delay write must not take the drive back out of service.
	a_ready_sticky: assert property (ready_o |=> ready_o)
		else $error("ready dropped without reset");

	// One history entry per error: the event pulse lasts a single cycle.
	a_event_once: assert property (slip_event_o |=> !slip_event_o)
		else $error("slip event longer than one cycle");
	c_ready_seen: cover property ($rose(ready_o));
	c_ctrl_write: cover property (obj_req_i && obj_wr_i && obj_index_i == `IDX_IF_CTRL);
	c_log_seen: cover property (error_log_o);

endmodule

// File: logic/slip_monitor.sv
`timescale 1ns/1ps
`include "drive_cfg_defines.svh"

module slip_monitor
(
	// Clock and control.
	input wire logic clk_i,
	input wire logic rst_ni,
	input wire logic ce_i,
	input wire logic tick_ms_i,
	// Speeds and limits.
	input wire logic velocity_mode_i,
	input wire logic signed [31:0] actual_speed_i,
	input wire logic signed [31:0] target_speed_i,
	input wire logic [31:0] slip_limit_i,
	input wire logic [15:0] timeout_ms_i,
	// Result.
	output logic slip_err_o
);

	drive_cfg_pkg::slip_state_s s_q, s_d;
	logic signed [32:0] diff;
	logic [32:0] mag;
	logic over;

	// Deviation magnitude, kept one bit wider so the subtraction cannot wrap.
	always_comb
	begin
		diff = 33'(actual_speed_i) - 33'(target_speed_i);
		mag = diff[32] ? 33'(-diff) : 33'(diff);
		over = velocity_mode_i && (mag > {1'b0, slip_limit_i});
	end

	// The counter stops one past the configured timeout so it never wraps back.
	always_comb
	begin
		s_d = s_q;
		if (!over)
		begin
			s_d.cnt = '0;
			s_d.err = 1'b0;
		end
		else if (tick_ms_i && s_q.cnt <= {1'b0, timeout_ms_i})
		begin
			s_d.cnt = s_q.cnt + 17'h00001;
		end
		if (over && s_q.cnt > {1'b0, timeout_ms_i})
		begin
			s_d.err = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_ni)
	begin
		if (!rst_ni)
			s_q <= '0;
		else if (ce_i)
			s_q <= s_d;
	end

	assign slip_err_o = s_q.err;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_ni);

	a_slip_restart: assert property (ce_i && !over |=> s_q.cnt == 17'h00000 && !slip_err_o)
		else $error("slip counter not restarted");
	a_slip_needs_time: assert property ($rose(slip_err_o) |-> $past(s_q.cnt) > {1'b0, $past(timeout_ms_i)})
		else $error("slip flagged before timeout");
	a_slip_needs_mode: assert property (slip_err_o |-> $past(velocity_mode_i))
		else $error("slip flagged outside velocity mode");
	c_slip_seen: cover property ($rose(slip_err_o));

endmodule

// File: logic/step_scaler.sv
`timescale 1ns/1ps

module step_scaler
(
	// Clock and control.
	input wire logic clk_i,
	input wire logic rst_ni,
	input wire logic ce_i,
	// Configuration.
	input wire logic ccw_mode_i,
	input wire logic signed [31:0] mult_i,
	input wire logic signed [31:0] div_i,
	// Step count in and scaled result out.
	input wire logic step_valid_i,
	input wire logic signed [31:0] step_count_i,
	output logic scaled_valid_o,
	output logic signed [31:0] scaled_steps_o
);

	drive_cfg_pkg::scale_state_s s_q, s_d;
	logic signed [63:0] prod;
	logic signed [63:0] quot;

	// A zero divider yields zero rather than an undefined quotient.
	always_comb
	begin
		prod = 64'(step_count_i) * 64'(mult_i);
		quot = (div_i == 32'sh0) ? 64'sh0 : prod / 64'(div_i);
		s_d = s_q;
		s_d.valid = step_valid_i;
		if (step_valid_i)
			s_d.steps = ccw_mode_i ? step_count_i : quot[31:0];
	end

	always_ff @(posedge clk_i or negedge rst_ni)
	begin
		if (!rst_ni)
			s_q <= '0;
		else if (ce_i)
			s_q <= s_d;
	end

	assign scaled_valid_o = s_q.valid;
	assign scaled_steps_o = s_q.steps;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_ni);

	a_scale_unity: assert property (ce_i && step_valid_i && !ccw_mode_i && mult_i == 32'sh1 && div_i == 32'sh1
		|=> scaled_steps_o == $past(step_count_i))
		else $error("unity scaling changed count");
	a_scale_bypass: assert property (ce_i && step_valid_i && ccw_mode_i |=> scaled_steps_o == $past(step_count_i))
		else $error("cw/ccw mode scaled the count");
	c_scale_run: cover property (scaled_valid_o && !ccw_mode_i);

endmodule
